// >>> common/rx_path_pkg.sv
// constants for the receive host data path: register map, fields, limits
// assumes a 32-bit host register port and byte-wide frames from the mac side
package rx_path_pkg;
  localparam logic [7:0] A_DATA = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_CFG  = 8'h08;
  localparam logic [7:0] A_DPC  = 8'h0c;
  localparam logic [7:0] A_COE  = 8'h10;
  localparam logic [7:0] A_MAC  = 8'h14;
  localparam logic [7:0] A_FILL = 8'h18;
  localparam logic [7:0] A_ERR  = 8'h1c;
  localparam int CFG_OFS   = 0;
  localparam int CFG_PAD   = 8;
  localparam int CFG_DUMP  = 15;
  localparam int CFG_BURST = 16;
  localparam int DPC_SKIP  = 31;
  localparam int COE_EN    = 0;
  localparam int MAC_PASS  = 16;
  localparam int FILL_DAT  = 0;
  localparam int FILL_STS  = 16;
  localparam int ERR_BIT   = 0;
  localparam int S_FILT  = 30;
  localparam int S_LEN   = 16;
  localparam int S_SUM   = 15;
  localparam int S_BCAST = 13;
  localparam int S_MIS   = 12;
  localparam int S_RUNT  = 11;
  localparam int S_MCAST = 10;
  localparam int S_LONG  = 7;
  localparam int S_LATE  = 6;
  localparam int S_CRC   = 1;
  localparam logic [13:0] MIN_FRAME = 14'h0040;
  localparam logic [13:0] MAX_FRAME = 14'h05ee;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_OFFS  = 3'h1,
    ST_BODY  = 3'h3,
    ST_CSUM  = 3'h2,
    ST_FLUSH = 3'h6,
    ST_PAD   = 3'h7,
    ST_STAT  = 3'h5
  } wst_t;
endpackage

// >>> hw/rx_host_datapath.sv
// receive host data path: data queue, status queue, host register port
// assumes frames arrive as bytes with a last marker; host obeys read limits
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module rx_host_datapath #(
  parameter int DEPTH  = 64,
  parameter int SDEPTH = 16
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rdata,
  // frame bytes from the mac interface layer
  input  wire logic        mif_valid,
  input  wire logic [7:0]  mif_byte,
  input  wire logic        mif_last,
  output logic             mif_ready,
  input  wire logic [31:0] mif_csum,
  input  wire logic        mif_filter_fail,
  input  wire logic        mif_bcast,
  input  wire logic        mif_mcast,
  input  wire logic        mif_type_mismatch,
  input  wire logic        mif_late_coll,
  input  wire logic        mif_crc_err,
  input  wire logic        mif_rx_er,
  // sticky error
  output logic             receive_error_flag
);
  localparam int AW = $clog2(DEPTH);
  localparam int SW = $clog2(SDEPTH);

  logic [31:0]      mem_ff [DEPTH];
  logic [DEPTH-1:0] sop_ff;
  logic [31:0]      smem_ff [SDEPTH];
  rx_path_pkg::wst_t st_ff, nxt_st;
  logic [AW:0]  wr_ff, nxt_wr, cm_ff, nxt_cm, fs_ff, nxt_fs;
  logic [AW:0]  rd_ff, nxt_rd, dav;
  logic [SW:0]  sw_ff, nxt_sw, sr_ff, nxt_sr, sav;
  logic [1:0]   lane_ff, nxt_lane;
  logic [31:0]  word_ff, nxt_word, pword;
  logic [2:0]   ocnt_ff, nxt_ocnt;
  logic [3:0]   bcnt_ff, nxt_bcnt;
  logic         first_ff, nxt_first;
  logic [13:0]  len_ff, nxt_len;
  logic [31:0]  stat_ff, nxt_stat, csum_ff, nxt_csum;
  logic         push, spush, sovf, uflow, dfull, sfull;
  logic [4:0]   ofs_ff, nxt_ofs;
  logic [3:0]   burst_ff, nxt_burst;
  logic         pad_ff, nxt_pad, dump_ff, nxt_dump;
  logic         skip_ff, nxt_skip, skmv_ff, nxt_skmv;
  logic         csen_ff, nxt_csen, pass_ff, nxt_pass;
  logic         err_ff, nxt_err;
  logic [31:0]  rdata_ff, nxt_rdata;

  assign dav   = cm_ff - rd_ff;
  assign sav   = sw_ff - sr_ff;
  assign dfull = (wr_ff - rd_ff) == (AW + 1)'(DEPTH);
  assign sfull = sav == (SW + 1)'(SDEPTH);
  assign mif_ready = (st_ff == rx_path_pkg::ST_BODY) && !dfull;
  assign rdata = rdata_ff;
  assign receive_error_flag = err_ff;

  // write side: frame into data queue, then status
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_wr    = wr_ff;
    nxt_cm    = cm_ff;
    nxt_fs    = fs_ff;
    nxt_lane  = lane_ff;
    nxt_word  = word_ff;
    nxt_ocnt  = ocnt_ff;
    nxt_bcnt  = bcnt_ff;
    nxt_first = first_ff;
    nxt_len   = len_ff;
    nxt_stat  = stat_ff;
    nxt_csum  = csum_ff;
    nxt_sw    = sw_ff;
    push      = 1'b0;
    pword     = '0;
    spush     = 1'b0;
    sovf      = 1'b0;
    case (st_ff)
      rx_path_pkg::ST_IDLE:
        if (mif_valid)
        begin
          nxt_st    = rx_path_pkg::ST_OFFS;
          nxt_fs    = wr_ff;
          nxt_ocnt  = ofs_ff[4:2];
          nxt_lane  = ofs_ff[1:0];
          nxt_word  = '0;
          nxt_bcnt  = '0;
          nxt_first = 1'b1;
          nxt_len   = '0;
        end
      rx_path_pkg::ST_OFFS:
        if (ocnt_ff == 3'h0)
          nxt_st = rx_path_pkg::ST_BODY;
        else if (!dfull)
        begin
          push     = 1'b1;
          nxt_ocnt = ocnt_ff - 3'h1;
        end
      rx_path_pkg::ST_BODY:
        if (mif_valid && !dfull)
        begin
          nxt_word[{lane_ff, 3'h0} +: 8] = mif_byte;
          nxt_lane = lane_ff + 2'h1;
          nxt_len  = len_ff + 14'h1;
          if (lane_ff == 2'h3)
          begin
            push     = 1'b1;
            pword    = nxt_word;
            nxt_word = '0;
          end
          if (mif_last)
          begin
            nxt_stat = '0;
            nxt_stat[rx_path_pkg::S_LEN +: 14] = nxt_len;
            nxt_stat[rx_path_pkg::S_FILT]  = mif_filter_fail;
            nxt_stat[rx_path_pkg::S_BCAST] = mif_bcast;
            nxt_stat[rx_path_pkg::S_MCAST] = mif_mcast;
            nxt_stat[rx_path_pkg::S_MIS]   = mif_type_mismatch;
            nxt_stat[rx_path_pkg::S_RUNT]  = nxt_len < rx_path_pkg::MIN_FRAME;
            nxt_stat[rx_path_pkg::S_LONG]  = nxt_len > rx_path_pkg::MAX_FRAME;
            nxt_stat[rx_path_pkg::S_LATE]  = mif_late_coll;
            nxt_stat[rx_path_pkg::S_CRC]   = mif_crc_err | mif_rx_er;
            nxt_stat[rx_path_pkg::S_SUM]   = nxt_stat[rx_path_pkg::S_RUNT]
              | nxt_stat[rx_path_pkg::S_LONG] | nxt_stat[rx_path_pkg::S_LATE]
              | nxt_stat[rx_path_pkg::S_CRC];
            nxt_csum = mif_csum;
            nxt_ocnt = '0;
            nxt_st   = csen_ff ? rx_path_pkg::ST_CSUM : rx_path_pkg::ST_FLUSH;
          end
        end
      rx_path_pkg::ST_CSUM:
        if (!dfull)
        begin
          // checksum bytes go in exactly like payload bytes
          nxt_word[{lane_ff, 3'h0} +: 8] = csum_ff[{ocnt_ff[1:0], 3'h0} +: 8];
          nxt_lane = lane_ff + 2'h1;
          nxt_ocnt = ocnt_ff + 3'h1;
          if (lane_ff == 2'h3)
          begin
            push     = 1'b1;
            pword    = nxt_word;
            nxt_word = '0;
          end
          if (ocnt_ff == 3'h3)
            nxt_st = rx_path_pkg::ST_FLUSH;
        end
      rx_path_pkg::ST_FLUSH:
        if (lane_ff == 2'h0)
          nxt_st = rx_path_pkg::ST_PAD;
        else if (!dfull)
        begin
          push     = 1'b1;
          pword    = word_ff;
          nxt_word = '0;
          nxt_lane = '0;
          nxt_st   = rx_path_pkg::ST_PAD;
        end
      rx_path_pkg::ST_PAD:
        if (!pad_ff || burst_ff == 4'h0 || bcnt_ff == 4'h0)
          nxt_st = rx_path_pkg::ST_STAT;
        else if (!dfull)
          push = 1'b1;
      rx_path_pkg::ST_STAT:
      begin
        nxt_st = rx_path_pkg::ST_IDLE;
        if (stat_ff[rx_path_pkg::S_RUNT] && !pass_ff)
          nxt_wr = fs_ff;
        else
        begin
          nxt_cm = wr_ff;
          if (sfull)
            sovf = 1'b1;
          else
            spush = 1'b1;
        end
      end
      default: nxt_st = rx_path_pkg::ST_IDLE;
    endcase
    if (push)
    begin
      nxt_wr    = wr_ff + (AW + 1)'(1);
      nxt_first = 1'b0;
      nxt_bcnt  = (5'(bcnt_ff) + 5'h1 == 5'(burst_ff)) ? 4'h0 : bcnt_ff + 4'h1;
    end
    if (spush)
      nxt_sw = sw_ff + (SW + 1)'(1);
    if (dump_ff)
    begin
      nxt_wr = '0;
      nxt_cm = '0;
      nxt_sw = '0;
      nxt_st = rx_path_pkg::ST_IDLE;
    end
  end

  // host side: register reads and writes, skip and dump
  always_comb
  begin
    nxt_rd    = rd_ff;
    nxt_sr    = sr_ff;
    nxt_rdata = '0;
    nxt_ofs   = ofs_ff;
    nxt_pad   = pad_ff;
    nxt_burst = burst_ff;
    nxt_dump  = 1'b0;
    nxt_skip  = skip_ff;
    nxt_skmv  = skmv_ff;
    nxt_csen  = csen_ff;
    nxt_pass  = pass_ff;
    nxt_err   = err_ff;
    uflow     = 1'b0;
    if (rd_en)
      case (addr)
        rx_path_pkg::A_DATA:
          if (dav == '0)
            uflow = 1'b1;
          else
          begin
            nxt_rdata = mem_ff[rd_ff[AW-1:0]];
            nxt_rd    = rd_ff + (AW + 1)'(1);
          end
        rx_path_pkg::A_STAT:
          if (sav == '0)
            uflow = 1'b1;
          else
          begin
            nxt_rdata = smem_ff[sr_ff[SW-1:0]];
            nxt_sr    = sr_ff + (SW + 1)'(1);
          end
        rx_path_pkg::A_CFG:
        begin
          nxt_rdata[rx_path_pkg::CFG_OFS +: 5]   = ofs_ff;
          nxt_rdata[rx_path_pkg::CFG_PAD]        = pad_ff;
          nxt_rdata[rx_path_pkg::CFG_DUMP]       = dump_ff;
          nxt_rdata[rx_path_pkg::CFG_BURST +: 4] = burst_ff;
        end
        rx_path_pkg::A_DPC:  nxt_rdata[rx_path_pkg::DPC_SKIP] = skip_ff;
        rx_path_pkg::A_COE:  nxt_rdata[rx_path_pkg::COE_EN] = csen_ff;
        rx_path_pkg::A_MAC:  nxt_rdata[rx_path_pkg::MAC_PASS] = pass_ff;
        rx_path_pkg::A_FILL:
        begin
          nxt_rdata[rx_path_pkg::FILL_DAT +: 16] = 16'(dav);
          nxt_rdata[rx_path_pkg::FILL_STS +: 8]  = 8'(sav);
        end
        rx_path_pkg::A_ERR:  nxt_rdata[rx_path_pkg::ERR_BIT] = err_ff;
        default: nxt_rdata = '0;
      endcase
    if (wr_en)
      case (addr)
        rx_path_pkg::A_CFG:
        begin
          nxt_ofs   = wdata[rx_path_pkg::CFG_OFS +: 5];
          nxt_pad   = wdata[rx_path_pkg::CFG_PAD];
          nxt_burst = wdata[rx_path_pkg::CFG_BURST +: 4];
          nxt_dump  = wdata[rx_path_pkg::CFG_DUMP];
        end
        rx_path_pkg::A_DPC:
          if (wdata[rx_path_pkg::DPC_SKIP])
          begin
            nxt_skip = 1'b1;
            nxt_skmv = 1'b0;
          end
        rx_path_pkg::A_COE:  nxt_csen = wdata[rx_path_pkg::COE_EN];
        rx_path_pkg::A_MAC:  nxt_pass = wdata[rx_path_pkg::MAC_PASS];
        rx_path_pkg::A_ERR:
          if (wdata[rx_path_pkg::ERR_BIT])
            nxt_err = 1'b0;
        default: nxt_err = nxt_err;
      endcase
    // one word per cycle; stops at next start marker or committed end
    // only the data read pointer moves; status pointers stay put
    if (skip_ff)
    begin
      if (dav == '0 || (skmv_ff && sop_ff[rd_ff[AW-1:0]]))
        nxt_skip = 1'b0;
      else
      begin
        nxt_rd   = rd_ff + (AW + 1)'(1);
        nxt_skmv = 1'b1;
      end
    end
    if (dump_ff)
    begin
      nxt_rd   = '0;
      nxt_sr   = '0;
      nxt_skip = 1'b0;
    end
    // set beats a same-cycle clear
    if (uflow || sovf)
      nxt_err = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_ff    <= rx_path_pkg::ST_IDLE;
      wr_ff    <= '0;
      cm_ff    <= '0;
      fs_ff    <= '0;
      rd_ff    <= '0;
      sw_ff    <= '0;
      sr_ff    <= '0;
      lane_ff  <= '0;
      word_ff  <= '0;
      ocnt_ff  <= '0;
      bcnt_ff  <= '0;
      first_ff <= 1'b0;
      len_ff   <= '0;
      stat_ff  <= '0;
      csum_ff  <= '0;
      ofs_ff   <= '0;
      pad_ff   <= 1'b0;
      burst_ff <= '0;
      dump_ff  <= 1'b0;
      skip_ff  <= 1'b0;
      skmv_ff  <= 1'b0;
      csen_ff  <= 1'b0;
      pass_ff  <= 1'b0;
      err_ff   <= 1'b0;
      rdata_ff <= '0;
      sop_ff   <= '0;
    end
    else
    begin
      st_ff    <= nxt_st;
      wr_ff    <= nxt_wr;
      cm_ff    <= nxt_cm;
      fs_ff    <= nxt_fs;
      rd_ff    <= nxt_rd;
      sw_ff    <= nxt_sw;
      sr_ff    <= nxt_sr;
      lane_ff  <= nxt_lane;
      word_ff  <= nxt_word;
      ocnt_ff  <= nxt_ocnt;
      bcnt_ff  <= nxt_bcnt;
      first_ff <= nxt_first;
      len_ff   <= nxt_len;
      stat_ff  <= nxt_stat;
      csum_ff  <= nxt_csum;
      ofs_ff   <= nxt_ofs;
      pad_ff   <= nxt_pad;
      burst_ff <= nxt_burst;
      dump_ff  <= nxt_dump;
      skip_ff  <= nxt_skip;
      skmv_ff  <= nxt_skmv;
      csen_ff  <= nxt_csen;
      pass_ff  <= nxt_pass;
      err_ff   <= nxt_err;
      rdata_ff <= nxt_rdata;
      if (push)
        sop_ff[wr_ff[AW-1:0]] <= first_ff;
    end
  end

  // queue storage has no reset; pointers guard it
  always_ff @(posedge clk)
  begin
    if (push)
      mem_ff[wr_ff[AW-1:0]] <= pword;
    if (spush)
      smem_ff[sw_ff[SW-1:0]] <= stat_ff;
  end

  a_status_last: assert property (@(posedge clk) disable iff (!rst_n)
    spush |-> st_ff == rx_path_pkg::ST_STAT && lane_ff == 2'h0 && !push)
    else $error("status pushed before data done");
  a_commit_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !spush && !sovf && !dump_ff |=> $stable(cm_ff))
    else $error("commit pointer moved without status");
  a_underrun_err: assert property (@(posedge clk) disable iff (!rst_n)
    rd_en && addr == rx_path_pkg::A_DATA && dav == '0 |=> receive_error_flag)
    else $error("data underrun not flagged");
  a_offset_lane: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == rx_path_pkg::ST_OFFS && !dump_ff |=> st_ff != rx_path_pkg::ST_BODY
      || lane_ff == $past(ofs_ff[1:0]))
    else $error("body starts at wrong byte lane");
  a_pad_done: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == rx_path_pkg::ST_PAD && nxt_st == rx_path_pkg::ST_STAT && pad_ff
      && burst_ff != 4'h0 |-> bcnt_ff == 4'h0)
    else $error("padding stopped off burst boundary");
  a_skip_ends: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(skip_ff) |-> ##[1:1000] !skip_ff)
    else $error("skip never completed");
  a_skip_status: assert property (@(posedge clk) disable iff (!rst_n)
    skip_ff && !dump_ff && !(rd_en && addr == rx_path_pkg::A_STAT) |=> $stable(sr_ff))
    else $error("skip disturbed status queue");
  a_dump_ptrs: assert property (@(posedge clk) disable iff (!rst_n)
    dump_ff |=> wr_ff == '0 && rd_ff == '0 && sw_ff == '0 && sr_ff == '0 && !dump_ff)
    else $error("dump left pointers set");
  a_runt_drop: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == rx_path_pkg::ST_STAT && stat_ff[rx_path_pkg::S_RUNT] && !pass_ff
      && !dump_ff |=> wr_ff == $past(fs_ff) && $stable(sw_ff))
    else $error("runt frame kept");
  a_err_summary: assert property (@(posedge clk) disable iff (!rst_n)
    rd_en && addr == rx_path_pkg::A_STAT && sav != '0 |=> rdata[rx_path_pkg::S_SUM]
      == (rdata[rx_path_pkg::S_RUNT] | rdata[rx_path_pkg::S_LONG]
      | rdata[rx_path_pkg::S_LATE] | rdata[rx_path_pkg::S_CRC]))
    else $error("error summary mismatch");
  a_long_flag: assert property (@(posedge clk) disable iff (!rst_n)
    spush |-> stat_ff[rx_path_pkg::S_LONG]
      == (stat_ff[rx_path_pkg::S_LEN +: 14] > rx_path_pkg::MAX_FRAME))
    else $error("too long flag wrong");
  a_stat_pop: assert property (@(posedge clk) disable iff (!rst_n)
    rd_en && addr == rx_path_pkg::A_STAT && sav != '0 && !dump_ff
      |=> sr_ff == (SW + 1)'($past(sr_ff) + 1))
    else $error("status pop not one entry");
endmodule
`default_nettype wire

// >>> test/rx_mac_source.sv
// frame byte source in place of the mac interface layer
// assumes the bench pulses go with len and seed held; one frame at a time
`timescale 1ns/1ps
`default_nettype none
module rx_mac_source (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // command from the bench
  input  wire logic        go,
  input  wire logic        slow,
  input  wire logic [13:0] len,
  input  wire logic [7:0]  seed,
  output logic             busy,
  // byte stream
  output logic             mif_valid,
  output logic [7:0]       mif_byte,
  output logic             mif_last,
  input  wire logic        mif_ready
);
  logic [13:0] cnt_ff;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy      <= 1'b0;
      mif_valid <= 1'b0;
      mif_last  <= 1'b0;
      mif_byte  <= 8'h5a;
      cnt_ff    <= 14'h0000;
    end
    else if (go && !busy)
    begin
      busy      <= 1'b1;
      mif_valid <= 1'b1;
      mif_byte  <= seed;
      mif_last  <= (len == 14'h0001);
      cnt_ff    <= 14'h0001;
    end
    else if (mif_valid && mif_ready)
    begin
      // idle byte is inverted so a stale value never looks valid
      mif_byte  <= mif_last ? ~mif_byte : mif_byte + 8'h01;
      mif_valid <= !mif_last && !slow;
      busy      <= !mif_last;
      mif_last  <= (cnt_ff + 14'h0001 == len);
      cnt_ff    <= cnt_ff + 14'h0001;
    end
    else if (busy && !mif_valid)
      mif_valid <= 1'b1;
  end
endmodule
`default_nettype wire

// >>> test/test_ethernet_rx_host_datapath.sv
// self-checking bench for the receive host data path
// assumes the mac source model and the constants of rx_path_pkg
`timescale 1ns/1ps
`default_nettype none
module test_ethernet_rx_host_datapath;
  logic        clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rdata;
  logic        mif_valid;
  logic [7:0]  mif_byte;
  logic        mif_last;
  logic        mif_ready;
  logic [31:0] csum;
  logic [6:0]  flg;
  logic        rx_err;
  logic        go;
  logic        slow;
  logic [13:0] len;
  logic [7:0]  seed;
  logic        busy;
  logic [31:0] d;
  int          mismatches;
  int          check_count;

  rx_host_datapath #(.DEPTH(512), .SDEPTH(16)) i_dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .mif_valid(mif_valid), .mif_byte(mif_byte),
    .mif_last(mif_last), .mif_ready(mif_ready), .mif_csum(csum),
    .mif_filter_fail(flg[6]), .mif_bcast(flg[5]), .mif_mcast(flg[4]),
    .mif_type_mismatch(flg[3]), .mif_late_coll(flg[2]), .mif_crc_err(flg[1]),
    .mif_rx_er(flg[0]), .receive_error_flag(rx_err));

  rx_mac_source i_src (
    .clk(clk), .rst_n(rst_n), .go(go), .slow(slow), .len(len), .seed(seed),
    .busy(busy), .mif_valid(mif_valid), .mif_byte(mif_byte),
    .mif_last(mif_last), .mif_ready(mif_ready));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic results();
    if (mismatches == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a, d);
    check(d, exp);
  endtask

  task automatic cfg(input logic [4:0] o, input logic p, input logic [3:0] bl);
    wr(rx_path_pkg::A_CFG, {12'h000, bl, 7'h00, p, 3'h0, o});
  endtask

  task automatic send(input logic [13:0] n, input logic [7:0] s, input logic [6:0] f);
    @(posedge clk);
    len  <= n;
    seed <= s;
    flg  <= f;
    go   <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 4000 && busy; i++)
      @(posedge clk);
  endtask

  // polls the status count; the frame tail has no fixed length
  task automatic wait_sts(input logic [7:0] n);
    for (int i = 0; i < 60; i++)
    begin
      rd(rx_path_pkg::A_FILL, d);
      if (d[23:16] === n)
        break;
    end
    check({24'h000000, d[23:16]}, {24'h000000, n});
  endtask

  function automatic logic [31:0] exp_sts(input logic [13:0] n, input logic [6:0] f);
    logic [31:0] s;
    s     = {2'b00, n, 16'h0000};
    s[30] = f[6];
    s[13] = f[5];
    s[10] = f[4];
    s[12] = f[3];
    s[6]  = f[2];
    s[1]  = f[1] | f[0];
    s[11] = n < 14'h0040;
    s[7]  = n > 14'h05ee;
    s[15] = s[11] | s[7] | s[6] | s[1];
    return s;
  endfunction

  function automatic int nwords(input int n, input int o, input bit c, input int bl);
    int nw;
    nw = (o + n + (c ? 4 : 0) + 3) / 4;
    if (bl != 0)
      nw = (nw + bl - 1) / bl * bl;
    return nw;
  endfunction

  function automatic logic [7:0] bval(input int i, input int n, input logic [7:0] s,
                                      input int o, input bit c);
    if (i < o)
      return 8'h00;
    if (i < o + n)
      return s + 8'(i - o);
    if (c && i < o + n + 4)
      return csum[(i - o - n) * 8 +: 8];
    return 8'h00;
  endfunction

  task automatic chk_data(input int n, input logic [7:0] s, input int o, input bit c,
                          input int bl);
    logic [31:0] e;
    for (int w = 0; w < nwords(n, o, c, bl); w++)
    begin
      for (int b = 0; b < 4; b++)
        e[b * 8 +: 8] = bval(w * 4 + b, n, s, o, c);
      rd(rx_path_pkg::A_DATA, d);
      check(d, e);
    end
  endtask

  // every flag alone, with offsets at both ends of the field
  task automatic t_fields();
    int ofs [7] = '{0, 1, 2, 3, 7, 30, 31};
    for (int i = 0; i < 7; i++)
    begin
      cfg(5'(ofs[i]), 1'b0, 4'h0);
      send(14'(64 + i), 8'(16 * i), 7'(1 << i));
      wait_sts(8'h01);
      rdc(rx_path_pkg::A_FILL, {16'h0001, 16'(nwords(64 + i, ofs[i], 0, 0))});
      rdc(rx_path_pkg::A_STAT, exp_sts(14'(64 + i), 7'(1 << i)));
      chk_data(64 + i, 8'(16 * i), ofs[i], 0, 0);
      rdc(rx_path_pkg::A_FILL, 32'h00000000);
    end
    cfg(5'h00, 1'b0, 4'h0);
  endtask

  // short frames kept only with pass-bad; over-long frames kept whole
  task automatic t_size();
    wr(rx_path_pkg::A_MAC, 32'h00010000);
    send(14'h0014, 8'h30, 7'h00);
    wait_sts(8'h01);
    rdc(rx_path_pkg::A_STAT, exp_sts(14'h0014, 7'h00));
    chk_data(20, 8'h30, 0, 0, 0);
    wr(rx_path_pkg::A_MAC, 32'h00000000);
    send(14'h0014, 8'h40, 7'h00);
    repeat (30) @(posedge clk);
    rdc(rx_path_pkg::A_FILL, 32'h00000000);
    send(14'h05ef, 8'h50, 7'h00);
    wait_sts(8'h01);
    rdc(rx_path_pkg::A_STAT, exp_sts(14'h05ef, 7'h00));
    chk_data(1519, 8'h50, 0, 0, 0);
  endtask

  task automatic t_csum();
    wr(rx_path_pkg::A_COE, 32'h00000001);
    cfg(5'h02, 1'b0, 4'h0);
    send(14'h0041, 8'h60, 7'h00);
    wait_sts(8'h01);
    rdc(rx_path_pkg::A_STAT, exp_sts(14'h0041, 7'h00));
    chk_data(65, 8'h60, 2, 1, 0);
    wr(rx_path_pkg::A_COE, 32'h00000000);
    cfg(5'h00, 1'b0, 4'h0);
  endtask

  // two padded packets, source stalling, statuses popped first
  task automatic t_stream();
    slow <= 1'b1;
    cfg(5'h03, 1'b1, 4'h4);
    send(14'h0046, 8'h70, 7'h00);
    send(14'h0051, 8'h90, 7'h00);
    wait_sts(8'h02);
    rdc(rx_path_pkg::A_FILL, {16'h0002, 16'(nwords(70, 3, 0, 4) + nwords(81, 3, 0, 4))});
    rdc(rx_path_pkg::A_STAT, exp_sts(14'h0046, 7'h00));
    rdc(rx_path_pkg::A_STAT, exp_sts(14'h0051, 7'h00));
    chk_data(70, 8'h70, 3, 0, 4);
    chk_data(81, 8'h90, 3, 0, 4);
    slow <= 1'b0;
    cfg(5'h00, 1'b0, 4'h0);
  endtask

  task automatic t_skip();
    send(14'h0040, 8'ha0, 7'h00);
    send(14'h0048, 8'hc0, 7'h00);
    wait_sts(8'h02);
    wr(rx_path_pkg::A_DPC, 32'h80000000);
    for (int i = 0; i < 200; i++)
    begin
      rd(rx_path_pkg::A_DPC, d);
      if (d[31] === 1'b0)
        break;
    end
    check({31'h0, d[31]}, 32'h00000000);
    rdc(rx_path_pkg::A_FILL, {16'h0002, 16'(nwords(72, 0, 0, 0))});
    rdc(rx_path_pkg::A_STAT, exp_sts(14'h0040, 7'h00));
    rdc(rx_path_pkg::A_STAT, exp_sts(14'h0048, 7'h00));
    chk_data(72, 8'hc0, 0, 0, 0);
  endtask

  task automatic t_dump();
    send(14'h0040, 8'h11, 7'h00);
    wait_sts(8'h01);
    wr(rx_path_pkg::A_CFG, 32'h00008000);
    rdc(rx_path_pkg::A_CFG, 32'h00000000);
    rdc(rx_path_pkg::A_FILL, 32'h00000000);
    send(14'h0042, 8'h22, 7'h00);
    wait_sts(8'h01);
    rdc(rx_path_pkg::A_STAT, exp_sts(14'h0042, 7'h00));
    chk_data(66, 8'h22, 0, 0, 0);
  endtask

  // over-reads of both queues, then the rst_n reset that recovers
  task automatic t_under();
    rdc(rx_path_pkg::A_DATA, 32'h00000000);
    check({31'h0, rx_err}, 32'h00000001);
    rdc(rx_path_pkg::A_ERR, 32'h00000001);
    wr(rx_path_pkg::A_ERR, 32'h00000001);
    rdc(rx_path_pkg::A_ERR, 32'h00000000);
    rdc(rx_path_pkg::A_STAT, 32'h00000000);
    rdc(rx_path_pkg::A_ERR, 32'h00000001);
    rdc(8'h20, 32'h00000000);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rdc(rx_path_pkg::A_ERR, 32'h00000000);
    check({31'h0, rx_err}, 32'h00000000);
  endtask

  initial
  begin
    #300000;
    mismatches++;
    results();
  end

  initial
  begin
    mismatches  = 0;
    check_count = 0;
    rst_n       = 1'b0;
    addr        = 8'h00;
    wdata       = 32'h00000000;
    wr_en       = 1'b0;
    rd_en       = 1'b0;
    csum        = 32'hc3a55a3c;
    flg         = 7'h00;
    go          = 1'b0;
    slow        = 1'b0;
    len         = 14'h0000;
    seed        = 8'h00;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_fields();
    t_size();
    t_csum();
    t_stream();
    t_skip();
    t_dump();
    t_under();
    results();
  end
endmodule
`default_nettype wire
